// [rtl/mbd_core.sv]
// Move, carry, increment and branch execution for an 8-bit core.
// Program memory and data RAM answer combinationally to the registered
// addresses; test inputs are asynchronous pins; timer flag is on-clock.
//
// Overview of operation
// - F8+r copies working register to accumulator
// - F0/F1 loads accumulator from RAM at register
// - 23 loads accumulator with immediate byte
// - A8+r/A0-1 store accumulator to register/RAM
// - B8+r/B0-1 store immediate to register/RAM
// - 28+r/20-21 swap accumulator with register/RAM
// - 30-31 swap only low nibbles with RAM
// - C7 copies status word to accumulator
// - D7 copies accumulator bit 3 to bank bit
// - A3 reads current-page table at accumulator
// - 18+r/10-11 increment register/RAM, wrapping
// - C8+r/C0-1 decrement register/RAM
// - Long jump: bank bits, opcode n, address
// - B3 jumps through current-page table at accumulator
// - E8+r decrements register, branches if nonzero
// - E0-1 decrements RAM byte, branches if nonzero
// - Branch when selected accumulator bit is one, except B2 (bit 5), which stores its second byte to RAM
// - F6 branches on carry, E6 on no carry
// - C6 branches on zero, 96 on nonzero
// - 36 branches test A low, 26 high
// - 56 branches test B high, 46 low
// - 16 branches timer flag set, 06 clear
// - E5 clears bank bits, F5 sets low only
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module mbd_core (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // APB slave
  input  wire mbd_pkg::mbd_apb_req_s apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Program memory
  output logic [12:0]                pm_addr,
  input  wire logic [7:0]            pm_rdata,
  // Data RAM
  output mbd_pkg::mbd_ram_req_s      ram_req,
  input  wire logic [7:0]            ram_rdata,
  // Test inputs and timer flag
  input  wire logic                  test_input_a,
  input  wire logic                  test_input_b,
  input  wire logic                  timer_overflow_flag
);

  mbd_pkg::mbd_st_s st_q;
  mbd_pkg::mbd_st_s st_d;

  // Working register index in the selected bank
  function automatic logic [3:0] ridx(input logic bank, input logic [2:0] r);
    ridx = {bank, r};
  endfunction

  // RAM-indirect forms use opcodes x0 and x1
  function automatic logic is_ram(input logic [7:0] op);
    logic grp;
    grp = (op[7:4] == 4'hF) || (op[7:4] == 4'hA) || (op[7:4] == 4'h2) ||
          (op[7:4] == 4'h3) || (op[7:4] == 4'h1) || (op[7:4] == 4'hC) ||
          (op[7:4] == 4'hB) || (op[7:4] == 4'hE);
    is_ram = grp && (op[3:1] == 3'h0);
  endfunction

  // Opcodes that carry a second byte
  function automatic logic is_two(input logic [7:0] op);
    logic br6;
    br6 = (op[3:0] == 4'h6) &&
          ((op[7:4] == 4'hF) || (op[7:4] == 4'hE) || (op[7:4] == 4'hC) ||
           (op[7:4] == 4'h9) || (op[7:4] <= 4'h5));
    is_two = (op == 8'h23) || (op[7:3] == 5'h17) || (op[7:3] == 5'h1D) ||
             (op[4:0] == 5'h04) || (op[4] && op[3:0] == 4'h2) || br6;
  endfunction

  // Branch condition of the second-byte cycle
  function automatic logic cond(input logic [7:0] op, input logic [7:0] a,
                                input logic cy, input logic ta, input logic tb,
                                input logic tf, input logic aux);
    cond = 1'b0;
    if (op[4] && op[3:0] == 4'h2) begin
      cond = a[op[7:5]];
    end else if (op[7:3] == 5'h1D || op[7:1] == 7'h70) begin
      cond = aux;
    end else begin
      case (op)
        8'hF6:   cond = cy;
        8'hE6:   cond = !cy;
        8'hC6:   cond = (a == 8'h00);
        8'h96:   cond = (a != 8'h00);
        8'h36:   cond = !ta;
        8'h26:   cond = ta;
        8'h56:   cond = tb;
        8'h46:   cond = !tb;
        8'h16:   cond = tf;
        8'h06:   cond = !tf;
        default: cond = 1'b0;
      endcase
    end
  endfunction

  always_comb begin
    logic [3:0] ri;
    logic [7:0] d;
    logic [7:0] b;
    logic [7:0] dec;
    ri  = ridx(st_q.program_status_word[mbd_pkg::MBD_PSW_BANK], pm_rdata[2:0]);
    d   = ram_rdata;
    b   = pm_rdata;
    dec = 8'h00;
    st_d = st_q;
    st_d.ram.we  = 1'b0;
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    // Two-flop synchronisers for the test pins
    st_d.ta_sync = {st_q.ta_sync[0], test_input_a};
    st_d.tb_sync = {st_q.tb_sync[0], test_input_b};

    // APB slave: one wait state, write lands on the completing edge
    if (apb_req.psel && apb_req.penable && !st_q.pready) begin
      st_d.pready = 1'b1;
      st_d.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        mbd_pkg::MBD_OFS_CTRL: st_d.prdata[mbd_pkg::MBD_CTRL_RUN] = st_q.run;
        mbd_pkg::MBD_OFS_STATUS: begin
          st_d.prdata[mbd_pkg::MBD_ST_PC_LSB +: 13] = st_q.pc;
          st_d.prdata[mbd_pkg::MBD_ST_PSW_LSB +: 8] = st_q.program_status_word;
          st_d.prdata[7:0] = st_q.acc;
        end
        default: st_d.pslverr = 1'b1;
      endcase
    end
    if (apb_req.psel && apb_req.penable && st_q.pready && apb_req.pwrite &&
        apb_req.paddr == mbd_pkg::MBD_OFS_CTRL) begin
      st_d.run = apb_req.pwdata[mbd_pkg::MBD_CTRL_RUN];
    end

    case (st_q.state)
      mbd_pkg::MBD_FETCH: begin
        if (st_q.run) begin
          st_d.op      = pm_rdata;
          st_d.pc      = st_q.pc + 13'h0001;
          st_d.pm_addr = st_q.pc + 13'h0001;
          if (is_ram(pm_rdata)) begin
            st_d.ram.addr = st_q.wreg[ridx(st_q.program_status_word[mbd_pkg::MBD_PSW_BANK],
                                          {2'b00, pm_rdata[0]})];
            st_d.state = mbd_pkg::MBD_MEM;
          end else if (is_two(pm_rdata)) begin
            st_d.state = mbd_pkg::MBD_IMM;
          end else if (pm_rdata == 8'hA3 || pm_rdata == 8'hB3) begin
            st_d.pm_addr = {st_d.pc[12:8], st_q.acc};
            st_d.state   = mbd_pkg::MBD_TABLE;
          end else begin
            case (pm_rdata[7:3])
              5'h1F: st_d.acc = st_q.wreg[ri];
              5'h15: st_d.wreg[ri] = st_q.acc;
              5'h05: begin
                st_d.acc     = st_q.wreg[ri];
                st_d.wreg[ri] = st_q.acc;
              end
              5'h03: st_d.wreg[ri] = st_q.wreg[ri] + 8'h01;
              5'h19: st_d.wreg[ri] = st_q.wreg[ri] - 8'h01;
              default: begin
                case (pm_rdata)
                  8'hC7: st_d.acc = st_q.program_status_word;
                  8'hD7: st_d.program_status_word[mbd_pkg::MBD_PSW_BANK] = st_q.acc[3];
                  8'h97: st_d.program_status_word[mbd_pkg::MBD_PSW_CY] = 1'b0;
                  8'hA7: st_d.program_status_word[mbd_pkg::MBD_PSW_CY] = !st_q.program_status_word[mbd_pkg::MBD_PSW_CY];
                  8'hE5: st_d.mb = 2'b00;
                  8'hF5: st_d.mb = 2'b01;
                  default: st_d.mb = st_q.mb;
                endcase
              end
            endcase
          end
        end
      end
      mbd_pkg::MBD_MEM: begin
        st_d.state    = mbd_pkg::MBD_FETCH;
        st_d.ram.we   = 1'b1;
        st_d.ram.wdata = d;
        case (st_q.op[7:4])
          4'hF: begin
            st_d.acc    = d;
            st_d.ram.we = 1'b0;
          end
          4'hA: st_d.ram.wdata = st_q.acc;
          4'h2: begin
            st_d.ram.wdata = st_q.acc;
            st_d.acc       = d;
          end
          4'h3: begin
            st_d.ram.wdata = {d[7:4], st_q.acc[3:0]};
            st_d.acc       = {st_q.acc[7:4], d[3:0]};
          end
          4'h1: st_d.ram.wdata = d + 8'h01;
          4'hC: st_d.ram.wdata = d - 8'h01;
          4'hB: begin
            st_d.ram.we = 1'b0;
            st_d.state  = mbd_pkg::MBD_IMM;
          end
          4'hE: begin
            dec            = d - 8'h01;
            st_d.ram.wdata = dec;
            st_d.aux       = (dec != 8'h00);
            st_d.state     = mbd_pkg::MBD_IMM;
          end
          default: st_d.ram.we = 1'b0;
        endcase
      end
      mbd_pkg::MBD_IMM: begin
        st_d.state   = mbd_pkg::MBD_FETCH;
        st_d.pc      = st_q.pc + 13'h0001;
        st_d.pm_addr = st_q.pc + 13'h0001;
        if (st_q.op == 8'h23) begin
          st_d.acc = b;
        end else if (st_q.op[7:3] == 5'h17) begin
          st_d.wreg[ridx(st_q.program_status_word[mbd_pkg::MBD_PSW_BANK], st_q.op[2:0])] = b;
        end else if (st_q.op[7:4] == 4'hB) begin
          st_d.ram.we    = 1'b1;
          st_d.ram.wdata = b;
        end else if (st_q.op[4:0] == 5'h04) begin
          st_d.pc      = {st_q.mb, st_q.op[7:5], b};
          st_d.pm_addr = {st_q.mb, st_q.op[7:5], b};
        end else begin
          if (st_q.op[7:3] == 5'h1D) begin
            dec = st_q.wreg[ridx(st_q.program_status_word[mbd_pkg::MBD_PSW_BANK], st_q.op[2:0])] - 8'h01;
            st_d.wreg[ridx(st_q.program_status_word[mbd_pkg::MBD_PSW_BANK], st_q.op[2:0])] = dec;
            st_d.aux = (dec != 8'h00);
          end
          if (cond(st_q.op, st_q.acc, st_q.program_status_word[mbd_pkg::MBD_PSW_CY], st_q.ta_sync[1],
                   st_q.tb_sync[1], timer_overflow_flag,
                   (st_q.op[7:3] == 5'h1D) ? (dec != 8'h00) : st_q.aux)) begin
            st_d.pc      = {st_q.pc[12:8], b};
            st_d.pm_addr = {st_q.pc[12:8], b};
          end
        end
      end
      mbd_pkg::MBD_TABLE: begin
        st_d.state = mbd_pkg::MBD_FETCH;
        if (st_q.op == 8'hA3) begin
          st_d.acc     = pm_rdata;
          st_d.pm_addr = st_q.pc;
        end else begin
          st_d.pc      = {st_q.pc[12:8], pm_rdata};
          st_d.pm_addr = {st_q.pc[12:8], pm_rdata};
        end
      end
      default: st_d.state = mbd_pkg::MBD_FETCH;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= mbd_pkg::MBD_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.prdata;
  assign pready  = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pm_addr = st_q.pm_addr;
  assign ram_req = st_q.ram;

  logic [3:0] a_ri;
  logic       a_fire;
  assign a_ri   = ridx(st_q.program_status_word[mbd_pkg::MBD_PSW_BANK], pm_rdata[2:0]);
  assign a_fire = st_q.run && st_q.state == mbd_pkg::MBD_FETCH;

  sequence s_fire(logic [7:0] code);
    a_fire && pm_rdata == code;
  endsequence

  sequence s_ram_fire(logic [6:0] grp);
    a_fire && pm_rdata[7:1] == grp ##1 st_q.state == mbd_pkg::MBD_MEM;
  endsequence

  sequence s_imm_op(logic [7:0] code);
    s_fire(code) ##1 st_q.state == mbd_pkg::MBD_IMM;
  endsequence

  // Taken branch lands on the second byte, untaken one steps past it
  property p_branch(logic [7:0] code, logic take);
    @(posedge clock) disable iff (srst)
      s_imm_op(code) |=> st_q.pc[7:0] ==
        ($past(take) ? $past(pm_rdata) : $past(st_q.pc[7:0]) + 8'h01);
  endproperty

  AST_REG_TO_ACC: assert property (@(posedge clock) disable iff (srst)
    a_fire && pm_rdata[7:3] == 5'h1F |=> st_q.acc == $past(st_q.wreg[a_ri]))
    else $error("register to accumulator move wrong");
  AST_ACC_TO_REG: assert property (@(posedge clock) disable iff (srst)
    a_fire && pm_rdata[7:3] == 5'h15 |=> st_q.wreg[$past(a_ri)] == $past(st_q.acc))
    else $error("accumulator to register move wrong");
  AST_PSW_READ: assert property (@(posedge clock) disable iff (srst)
    s_fire(8'hC7) |=> st_q.acc == $past(st_q.program_status_word))
    else $error("status word read wrong");
  AST_BANK_BIT: assert property (@(posedge clock) disable iff (srst)
    s_fire(8'hD7) |=> st_q.program_status_word == {$past(st_q.program_status_word[7:4]), $past(st_q.acc[3]),
                                    $past(st_q.program_status_word[2:0])})
    else $error("bank bit write wrong");
  AST_CARRY_CLR: assert property (@(posedge clock) disable iff (srst)
    s_fire(8'h97) |=> !st_q.program_status_word[mbd_pkg::MBD_PSW_CY] && $stable(st_q.acc))
    else $error("carry clear wrong");
  AST_REG_INC: assert property (@(posedge clock) disable iff (srst)
    a_fire && pm_rdata[7:3] == 5'h03 |=>
      st_q.wreg[$past(a_ri)] == $past(st_q.wreg[a_ri]) + 8'h01)
    else $error("register increment wrong");
  AST_LONG_JUMP: assert property (@(posedge clock) disable iff (srst)
    a_fire && pm_rdata[4:0] == 5'h04 ##1 st_q.state == mbd_pkg::MBD_IMM |=>
      st_q.pc == {$past(st_q.mb), $past(st_q.op[7:5]), $past(pm_rdata)})
    else $error("long jump target wrong");
  AST_TABLE_READ: assert property (@(posedge clock) disable iff (srst)
    s_fire(8'hA3) |=> st_q.pm_addr == {st_q.pc[12:8], $past(st_q.acc)} ##1
      st_q.acc == $past(pm_rdata) && st_q.state == mbd_pkg::MBD_FETCH)
    else $error("page table read wrong");
  AST_PAGE_KEPT: assert property (@(posedge clock) disable iff (srst)
    st_q.state == mbd_pkg::MBD_IMM && st_q.op[3:0] == 4'h6 |=>
      st_q.pc[12:8] == $past(st_q.pc[12:8]) && st_q.state == mbd_pkg::MBD_FETCH)
    else $error("conditional branch changed page");
  AST_BANK_SEL: assert property (@(posedge clock) disable iff (srst)
    s_fire(8'hF5) |=> st_q.mb == 2'b01)
    else $error("bank select wrong");
  AST_RAM_TO_ACC: assert property (@(posedge clock) disable iff (srst)
    s_ram_fire(7'h78) |=> st_q.acc == $past(ram_rdata))
    else $error("accumulator load from RAM wrong");
  AST_IMM_TO_ACC: assert property (@(posedge clock) disable iff (srst)
    s_imm_op(8'h23) |=> st_q.acc == $past(pm_rdata))
    else $error("immediate accumulator load wrong");
  AST_NIBBLE_SWAP: assert property (@(posedge clock) disable iff (srst)
    s_ram_fire(7'h18) |=> st_q.acc == {$past(st_q.acc[7:4]), $past(ram_rdata[3:0])} &&
      st_q.ram.we && st_q.ram.wdata == {$past(ram_rdata[7:4]), $past(st_q.acc[3:0])})
    else $error("low nibble swap wrong");
  AST_REG_DEC: assert property (@(posedge clock) disable iff (srst)
    a_fire && pm_rdata[7:3] == 5'h19 |=>
      st_q.wreg[$past(a_ri)] == $past(st_q.wreg[a_ri]) - 8'h01)
    else $error("register decrement wrong");
  AST_NO_CARRY_BRANCH: assert property (
    p_branch(8'hE6, !st_q.program_status_word[mbd_pkg::MBD_PSW_CY]))
    else $error("no-carry branch wrong");
  AST_ZERO_BRANCH: assert property (
    p_branch(8'hC6, st_q.acc == 8'h00))
    else $error("zero branch wrong");
  AST_TEST_A_BRANCH: assert property (
    p_branch(8'h36, !st_q.ta_sync[1]))
    else $error("test input A branch wrong");
  AST_TIMER_BRANCH: assert property (
    p_branch(8'h16, timer_overflow_flag))
    else $error("timer flag branch wrong");

endmodule

// [rtl/mbd_pkg.sv]
// Constants, states and carrier structs of the move and branch decoder.
// Assumes a single core clock; memories read combinationally.
package mbd_pkg;

  // Register map, APB byte addresses
  localparam logic [11:0] MBD_OFS_CTRL   = 12'h000;
  localparam logic [11:0] MBD_OFS_STATUS = 12'h004;

  // Field positions
  localparam int MBD_CTRL_RUN  = 0;
  localparam int MBD_PSW_CY    = 7;
  localparam int MBD_PSW_BANK  = 3;
  localparam int MBD_ST_PC_LSB = 16;
  localparam int MBD_ST_PSW_LSB = 8;

  // Values after reset
  localparam logic [12:0] MBD_PC_RST  = 13'h0000;
  localparam logic [7:0]  MBD_PSW_RST = 8'h00;
  localparam logic        MBD_RUN_RST = 1'b0;

  typedef enum logic [2:0] {
    MBD_FETCH,
    MBD_MEM,
    MBD_IMM,
    MBD_TABLE
  } mbd_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mbd_apb_req_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } mbd_ram_req_s;

  typedef struct packed {
    mbd_state_e        state;
    logic              run;
    logic [7:0]        acc;
    logic [7:0]        program_status_word;
    logic [12:0]       pc;
    logic [1:0]        mb;
    logic [7:0]        op;
    logic              aux;
    logic [15:0][7:0]  wreg;
    logic [12:0]       pm_addr;
    mbd_ram_req_s      ram;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [1:0]        ta_sync;
    logic [1:0]        tb_sync;
  } mbd_st_s;

  localparam mbd_st_s MBD_ST_RST = '0;

endpackage

// [test/mbd_mem.sv]
// Far-side model: program memory and internal data RAM of the core.
// Assumes the bench loads program bytes directly into rom while idle.
`timescale 1ns/1ps
module mbd_mem (
  // Clock
  input  wire logic                  clock,
  // Program memory
  input  wire logic [12:0]           pm_addr,
  output logic [7:0]                 pm_rdata,
  // Data RAM
  input  wire mbd_pkg::mbd_ram_req_s ram_req,
  output logic [7:0]                 ram_rdata
);
  logic [7:0] rom [0:8191];
  logic [7:0] ram [0:255];

  // Both memories answer combinationally to the registered addresses
  assign pm_rdata  = rom[pm_addr];
  assign ram_rdata = ram[ram_req.addr];

  // Write lands at the edge ending the strobe cycle
  always @(posedge clock) begin
    if (ram_req.we) begin
      ram[ram_req.addr] <= ram_req.wdata;
    end
  end
endmodule

// [test/move_and_branch_decoder_tb.sv]
// Self-checking bench for the move and branch decoder.
// Assumes mbd_mem as program memory and RAM; software runs the core over APB.
`timescale 1ns/1ps
module move_and_branch_decoder_tb;
  logic                  clock;
  logic                  srst;
  mbd_pkg::mbd_apb_req_s apb_req;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [12:0]           pm_addr;
  logic [7:0]            pm_rdata;
  mbd_pkg::mbd_ram_req_s ram_req;
  logic [7:0]            ram_rdata;
  logic                  test_input_a;
  logic                  test_input_b;
  logic                  timer_overflow_flag;
  int                    err_total;
  int                    total_checks;
  int                    cycles;

  mbd_core DUT (.clock(clock), .srst(srst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .ram_req(ram_req), .ram_rdata(ram_rdata), .test_input_a(test_input_a),
    .test_input_b(test_input_b), .timer_overflow_flag(timer_overflow_flag));
  mbd_mem u_mem (.clock(clock), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .ram_req(ram_req), .ram_rdata(ram_rdata));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("ERROR run_time expected below 20000 seen %0d", cycles);
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= wd;
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 8192; i++) u_mem.rom[i] = 8'h00;
    for (int i = 0; i < 256; i++) u_mem.ram[i] = 8'h00;
  endtask

  // Runs until the core idles in its closing loop at address at
  task automatic finish_run(input logic [12:0] at, input logic [7:0] program_status_word, input logic [7:0] acc);
    logic [31:0] d;
    logic        e;
    int          n;
    n = 0;
    apb(1'b1, mbd_pkg::MBD_OFS_CTRL, 32'h0000_0001, d, e);
    do begin
      apb(1'b0, mbd_pkg::MBD_OFS_STATUS, 32'h0, d, e);
      n++;
    end while ((d[28:16] & 13'h1FFE) !== at && n < 100);
    apb(1'b1, mbd_pkg::MBD_OFS_CTRL, 32'h0, d, e);
    apb(1'b0, mbd_pkg::MBD_OFS_STATUS, 32'h0, d, e);
    check("pc", {19'h0, at}, {19'h0, d[28:16] & 13'h1FFE});
    check("psw", {24'h0, program_status_word}, {24'h0, d[15:8]});
    check("acc", {24'h0, acc}, {24'h0, d[7:0]});
  endtask

  task automatic test_regs();
    logic [31:0] d;
    logic        e;
    apb(1'b0, mbd_pkg::MBD_OFS_STATUS, 32'h0, d, e);
    check("status_rst", 32'h0, d);
    apb(1'b1, mbd_pkg::MBD_OFS_STATUS, 32'hFFFF_FFFF, d, e);
    apb(1'b0, mbd_pkg::MBD_OFS_STATUS, 32'h0, d, e);
    check("status_ro", 32'h0, d);
    apb(1'b0, 12'h008, 32'h0, d, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    check("unmapped_data", 32'h0, d);
    apb(1'b1, mbd_pkg::MBD_OFS_CTRL, 32'h0000_0001, d, e);
    apb(1'b0, mbd_pkg::MBD_OFS_CTRL, 32'h0, d, e);
    check("ctrl_run", 32'h1, d);
    apb(1'b1, mbd_pkg::MBD_OFS_CTRL, 32'h0, d, e);
    $display("test regs done");
  endtask

  // Moves, swaps, carry, counts, table read, page and long jumps
  task automatic test_moves();
    logic [7:0] p [50] = '{8'hB8, 8'h10, 8'hB9, 8'h11, 8'h23, 8'hA5, 8'hA0, 8'hB1, 8'h3C,
      8'h23, 8'h12, 8'h31, 8'h20, 8'h11, 8'hC0, 8'hAA, 8'h23, 8'h00, 8'h2A, 8'h1A,
      8'hCA, 8'hCA, 8'hFA, 8'hB9, 8'h21, 8'hA1, 8'hA7, 8'hC7, 8'hB9, 8'h22, 8'hA1,
      8'h97, 8'hBB, 8'h03, 8'hEB, 8'h22, 8'hB8, 8'h30, 8'hB0, 8'h02, 8'hE0, 8'h28,
      8'h23, 8'h08, 8'hD7, 8'hA8, 8'h23, 8'h70, 8'hA3, 8'hB3};
    do_reset();
    foreach (p[i]) u_mem.rom[i] = p[i];
    u_mem.rom[13'h070] = 8'h74;
    u_mem.rom[13'h071] = 8'hB3;
    u_mem.rom[13'h074] = 8'h80;
    u_mem.ram[8'h08]   = 8'h5A;
    u_mem.rom[13'h080] = 8'hA1;
    u_mem.rom[13'h081] = 8'hF5;
    u_mem.rom[13'h082] = 8'h24;
    u_mem.rom[13'h083] = 8'h00;
    u_mem.rom[13'h900] = 8'hE5;
    u_mem.rom[13'h901] = 8'hF0;
    u_mem.rom[13'h902] = 8'h04;
    u_mem.rom[13'h903] = 8'h60;
    u_mem.rom[13'h060] = 8'h04;
    u_mem.rom[13'h061] = 8'h60;
    finish_run(13'h060, 8'h08,
      8'h5A);
    check("ram_00", 32'h74, {24'h0, u_mem.ram[8'h00]});
    check("ram_10", 32'h1B, {24'h0, u_mem.ram[8'h10]});
    check("ram_11", 32'h33, {24'h0, u_mem.ram[8'h11]});
    check("ram_21", 32'hFF, {24'h0, u_mem.ram[8'h21]});
    check("ram_22", 32'h80, {24'h0, u_mem.ram[8'h22]});
    check("ram_30", 32'h00, {24'h0, u_mem.ram[8'h30]});
    $display("test moves done");
  endtask

  // Every flag, test-pin and accumulator-zero branch, plus bit branches 12, 92 and F2, once taken and once not, over two flag sets
  task automatic test_branches(input logic p);
    logic [7:0] ops [13] = '{8'h26, 8'h36, 8'h56, 8'h46, 8'h16, 8'h06, 8'hF6, 8'hE6,
      8'hC6, 8'h96, 8'h12, 8'h92, 8'hF2};
    logic [7:0] a;
    logic       tk;
    do_reset();
    test_input_a        <= !p;
    test_input_b        <= p;
    timer_overflow_flag <= p;
    u_mem.rom[0] = 8'h23;
    u_mem.rom[1] = p ? 8'hFF : 8'h00;
    u_mem.rom[2] = p ? 8'hA7 : 8'h00;
    a = 8'h04;
    foreach (ops[i]) begin
      tk = p ^ (ops[i] inside {8'h26, 8'h46, 8'h06, 8'hE6, 8'hC6});
      u_mem.rom[a] = ops[i];
      if (tk) begin
        u_mem.rom[a + 8'h01] = a + 8'h04;
        u_mem.rom[a + 8'h02] = 8'h04;
        u_mem.rom[a + 8'h03] = a + 8'h02;
        a = a + 8'h04;
      end else begin
        u_mem.rom[a + 8'h01] = a;
        a = a + 8'h02;
      end
    end
    u_mem.rom[a] = 8'h04;
    u_mem.rom[a + 8'h01] = a;
    finish_run({5'h0, a}, p ? 8'h80 : 8'h00,
      p ? 8'hFF : 8'h00);
    $display("test branches pass %0d done", p);
  endtask

  initial begin
    srst                = 1'b1;
    apb_req             = '0;
    test_input_a        = 1'b0;
    test_input_b        = 1'b0;
    timer_overflow_flag = 1'b0;
    err_total           = 0;
    total_checks        = 0;
    cycles              = 0;
    do_reset();
    test_regs();
    test_moves();
    test_branches(1'b0);
    test_branches(1'b1);
    stop_test();
  end
endmodule
